// ==== dv/mft_pin_src.sv ====
// mft_pin_src.sv: model of the source driving the shared event pin.
// assumes clk is the timer clock; commanded by tb_top.
`default_nettype none
module mft_pin_src
(
  // clock
  input  wire logic       clk,
  // command: flip the pin after gap cycles
  input  wire logic       go,
  input  wire logic [7:0] gap,
  // pin and progress
  output var  logic       pin,
  output var  logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_r; // cycles still to wait
  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
    wait_r = 8'h00;
  end
  // the pin is always driven, so its gap, fast or slow, is the only stress it can give
  always @(posedge clk)
  begin
    if (go)
    begin
      busy <= 1'b1;
      wait_r <= gap;
    end
    else if (busy && wait_r == 8'h00)
    begin
      pin <= ~pin;
      busy <= 1'b0;
    end
    else if (busy)
      wait_r <= wait_r - 8'h01;
  end
endmodule // mft_pin_src
`default_nettype wire

// ==== dv/mft_timer_properties.sv ====
// mft_timer_properties.sv: port checker for the timer, bound at the foot.
// assumes one clock and a synchronous active-low reset.
`default_nettype none
module mft_timer_properties
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // register bus
  input  wire mft_pkg::mft_wreq_s wreq,
  input  wire mft_pkg::mft_rreq_s rreq,
  input  wire mft_pkg::mft_rsp_s  rsp,
  // pin and interrupt
  input  wire logic              event_pin,
  input  wire logic              timer_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import mft_pkg::*;
  logic [3:0] since_w_r; // cycles since write data was taken, saturating
  // counter lets a flag drop be tied back to a recent write
  always_ff @(posedge clk)
    since_w_r <= (!rst_n || rsp.wready) ? 4'h0 : ((since_w_r == 4'hF) ? 4'hF : since_w_r + 4'h1);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ************************************************************
  // assertions
  // ************************************************************
  AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_n |=> (rsp == '0) && !timer_irq)
    else $error("outputs not quiet after reset");
  AST_BVALID_HOLD: assert property (rsp.bvalid && !wreq.bready |=> rsp.bvalid && $stable(rsp.bresp))
    else $error("write response dropped before taken");
  AST_RVALID_HOLD: assert property (rsp.rvalid && !rreq.rready |=> rsp.rvalid && $stable(rsp.rdata))
    else $error("read data dropped before taken");
  AST_READ_ANSWER: assert property (rsp.arready |-> rsp.rvalid)
    else $error("read taken without data");
  AST_ERR_ZERO: assert property (rsp.rvalid && rsp.rresp == MFT_RESP_SLVERR |-> rsp.rdata == 32'h0)
    else $error("error read carries data");
  AST_ONE_AT_A_TIME: assert property (!(rsp.bvalid && rsp.rvalid))
    else $error("write and read answered together");
  AST_AR_PULSE: assert property (rsp.arready && clk_en |=> !rsp.arready)
    else $error("read ready longer than one cycle");
  AST_B_AFTER_W: assert property ($rose(rsp.bvalid) |-> since_w_r <= 4'h2)
    else $error("write response without recent data");
  AST_IRQ_CLEAR: assert property ($fell(timer_irq) |-> since_w_r <= 4'h6)
    else $error("interrupt dropped without a write");
  AST_FREEZE: assert property (!clk_en |=> $stable(rsp) && $stable(timer_irq))
    else $error("outputs moved while disabled");
  COV_WRITE: cover property (rsp.bvalid && wreq.bready);
  COV_READ: cover property (rsp.rvalid && rreq.rready);
  COV_IRQ: cover property ($rose(timer_irq));
  COV_PIN_IRQ: cover property ($rose(event_pin) ##[3:6] $rose(timer_irq));
endmodule // mft_timer_properties
bind mft_timer mft_timer_properties u_props (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .wreq(wreq),
  .rreq(rreq), .rsp(rsp), .event_pin(event_pin), .timer_irq(timer_irq));
`default_nettype wire

// ==== dv/tb_top.sv ====
// tb_top.sv: self-checking bench for the timer over axi4-lite.
// assumes mft_pkg, mft_timer, mft_pin_src and the checker are compiled first.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mft_pkg::*;
  // byte addresses of the registers
  localparam logic [13:0] A_LO = 14'h028, A_HI = 14'h02C, A_FC = 14'h024, A_PIN = 14'h090;
  localparam logic [13:0] A_CE = 14'h098, A_ST = 14'h084, A_CTL = 14'h100, A_BAD = 14'h3FC;
  logic        clk, rst_n, clk_en, go, busy, pin, timer_irq;
  logic [7:0]  gap;   // pin source pace
  mft_wreq_s   wreq;
  mft_rreq_s   rreq;
  mft_rsp_s    rsp;
  logic [1:0]  r;     // last response code
  logic [31:0] d;     // last read data
  int          mismatches, total_checks;
  int          dv[7] = '{2048, 512, 128, 32, 8, 4, 2}; // tick period per clock code
  mft_timer DUT (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .wreq(wreq), .rreq(rreq), .rsp(rsp),
    .event_pin(pin), .timer_irq(timer_irq));
  mft_pin_src u_src (.clk(clk), .go(go), .gap(gap), .pin(pin), .busy(busy));
  // ************************************************************
  // clock, watchdog and tasks
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // both channels offered together, each released when taken
  task automatic wr(input logic [13:0] a, input logic [3:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    wreq <= '{1'b1, a, 1'b1, {28'h0, v}, 4'hF, 1'b0};
    while (!(aw && w))
    begin
      @(posedge clk);
      if (rsp.awready) aw = 1'b1;
      if (rsp.wready) w = 1'b1;
      wreq.awvalid <= !aw;
      wreq.wvalid <= !w;
    end
    while (!rsp.bvalid) @(posedge clk);
    wreq.bready <= 1'b1;
    @(posedge clk);
    r = rsp.bresp;
    wreq.bready <= 1'b0;
  endtask
  // rready raised late on purpose, so the answer must stand
  task automatic rd(input logic [13:0] a);
    @(posedge clk);
    rreq <= '{1'b1, a, 1'b0};
    @(posedge clk);
    while (!rsp.arready) @(posedge clk);
    rreq.arvalid <= 1'b0;
    rreq.rready <= 1'b1;
    @(posedge clk);
    d = rsp.rdata;
    r = rsp.rresp;
    rreq.rready <= 1'b0;
  endtask
  task automatic cnt(output logic [7:0] c);
    rd(A_HI);
    c[7:4] = d[3:0];
    rd(A_LO);
    c[3:0] = d[3:0];
  endtask
  task automatic ld(input logic [7:0] v);
    wr(A_LO, v[3:0]);
    wr(A_HI, v[7:4]);
  endtask
  task automatic tog(input int n, input logic [7:0] g);
    repeat (n)
    begin
      @(posedge clk);
      gap <= g;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      while (busy) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    logic [7:0] c;
    rst_n = 1'b0; clk_en = 1'b1; go = 1'b0; gap = 8'h00; wreq = '0; rreq = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cnt(c); chk(c, 8'h00);
    rd(A_ST); chk(d, 32'h0);
    rd(A_FC); chk(r, 2'h2);
    rd(A_BAD); chk(r, 2'h2);
    chk(d, 32'h0);
    wr(A_BAD, 4'h1); chk(r, 2'h2);
    // clock code 111 with the pin unrouted: counter stands still
    wr(A_FC, 4'h7); chk(r, 2'h0);
    wr(A_LO, 4'h5);
    cnt(c); chk(c, 8'h00);
    wr(A_HI, 4'hA);
    cnt(c); chk(c, 8'hA5);
    wr(A_HI, 4'h3);
    cnt(c); chk(c, 8'h35);
    wr(A_CTL, 4'h1);
    cnt(c); chk(c, 8'h00);
    wr(A_CTL, 4'h0);
    wr(A_FC, 4'h7);
    wr(A_HI, 4'h6);
    cnt(c); chk(c, 8'h60);
    // edges ignored until routed, then each edge mode at its own pace
    wr(A_CE, 4'h3);
    ld(8'h00);
    tog(4, 8'h02);
    cnt(c); chk(c, 8'h00);
    wr(A_PIN, 4'h1);
    for (int e = 0; e < 4; e++)
    begin
      wr(A_CE, e[3:0]);
      ld(8'h00);
      tog(4, 8'(e * 9));
      cnt(c); chk(c, 8'((e & 1) * 2 + (e >> 1) * 2));
    end
    ld(8'h0F);
    rd(A_HI); chk(d, 32'h0);
    tog(1, 8'h00);
    rd(A_LO); chk(d, 32'hF);
    rd(A_HI); chk(d, 32'h1);
    // overflow in free-running then reload mode
    ld(8'hFE);
    tog(2, 8'h01);
    cnt(c); chk(c, 8'h00);
    chk(timer_irq, 1'b1);
    rd(A_ST); chk(d, 32'h1);
    wr(A_ST, 4'h0);
    rd(A_ST); chk(d, 32'h0);
    chk(timer_irq, 1'b0);
    @(posedge clk);
    clk_en <= 1'b0;
    repeat (4) @(posedge clk);
    clk_en <= 1'b1;
    wr(A_FC, 4'hF);
    ld(8'hF4);
    tog(12, 8'h00);
    cnt(c); chk(c, 8'hF4);
    tog(1, 8'h00);
    cnt(c); chk(c, 8'hF5);
    wr(A_ST, 4'h0);
    // prescaler taps; the three longest would dominate run time
    wr(A_CE, 4'h0);
    for (int k = 3; k < 7; k++)
    begin
      wr(A_FC, 4'h7);
      ld(8'h00);
      wr(A_FC, k[3:0]);
      repeat (128) @(posedge clk);
      wr(A_FC, 4'h7);
      cnt(c); chk(c >= 8'(128 / dv[k]) && c <= 8'(136 / dv[k] + 1), 1'b1);
    end
    // capture on rising edges with 2-cycle ticks
    if (pin) tog(1, 8'h00);
    wr(A_FC, 4'h6);
    wr(A_CE, 4'h6);
    tog(1, 8'd60);
    rd(A_ST); chk(d, 32'h3);
    chk(timer_irq, 1'b1);
    rd(A_LO);
    c[3:0] = d[3:0];
    rd(A_HI);
    c[7:4] = d[3:0];
    rd(A_LO); chk(d[3:0], c[3:0]);
    chk(c >= 8'd30 && c <= 8'd40, 1'b1);
    tog(2, 8'h05);
    rd(A_ST); chk(d, 32'h7);
    // keep capture status, clear the rest, then let the counter overflow
    wr(A_ST, 4'h2);
    rd(A_ST); chk(d, 32'h2);
    repeat (520) @(posedge clk);
    rd(A_ST); chk(d, 32'h7);
    // second reset mid-run drops capture mode and flags
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_ST); chk(d, 32'h0);
    cnt(c); chk(c, 8'h00);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire

// ==== rtl/mft_defs.svh ====
// mft_defs.svh: register offsets, field positions, reset values and tick periods
// for the multifunction 8-bit timer; included by the package and the timer.
`ifndef MFT_DEFS_SVH
`define MFT_DEFS_SVH

// ************************************************************
// register word indexes; the byte address is four times the index
// ************************************************************
`define MFT_IDX_LOAD_LOW   12'h00A
`define MFT_IDX_LOAD_HIGH  12'h00B
`define MFT_IDX_PIN_FUNC   12'h024
`define MFT_IDX_CAP_EDGE   12'h026
`define MFT_IDX_FUNC_CLK   12'h009
`define MFT_IDX_STATUS     12'h021
`define MFT_IDX_CONTROL    12'h040
`define MFT_ADDR_W         14

// ************************************************************
// field positions
// ************************************************************
`define MFT_RELOAD_BIT     3
`define MFT_CAPTURE_BIT    2
`define MFT_ROUTE_BIT      0
`define MFT_ST_IRQ_BIT     0
`define MFT_ST_CSF_BIT     1
`define MFT_ST_CEF_BIT     2
`define MFT_CTL_STOP_BIT   0

// ************************************************************
// reset values
// ************************************************************
`define MFT_FUNC_CLK_RST   4'h0
`define MFT_CAP_EDGE_RST   3'h0
`define MFT_LOAD_LOW_RST   4'h0
`define MFT_PIN_FUNC_RST   2'h0

// ************************************************************
// prescaler masks, one less than each tick period in system cycles; external clock code
// ************************************************************
`define MFT_DIV_2048       12'h7FF
`define MFT_DIV_512        12'h1FF
`define MFT_DIV_128        12'h07F
`define MFT_DIV_32         12'h01F
`define MFT_DIV_8          12'h007
`define MFT_DIV_4          12'h003
`define MFT_DIV_2          12'h001
`define MFT_CLK_EXTERNAL   3'h7

`endif

// ==== rtl/mft_pkg.sv ====
// mft_pkg.sv: types shared by the timer and its bench.
// assumes mft_defs.svh is on the include path.
`default_nettype none
`include "mft_defs.svh"
package mft_pkg;
  // axi4-lite response codes
  typedef enum logic [1:0] {MFT_RESP_OKAY = 2'h0, MFT_RESP_SLVERR = 2'h2} mft_resp_e;
  // bus handshake phases, one-hot
  typedef enum logic [2:0] {
    MFT_BUS_IDLE = 3'b001,
    MFT_BUS_WRSP = 3'b010,
    MFT_BUS_RRSP = 3'b100
  } mft_bus_e;
  // write channels
  typedef struct packed {
    logic                      awvalid;
    logic [`MFT_ADDR_W-1:0]    awaddr;
    logic                      wvalid;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bready;
  } mft_wreq_s;
  // read channels
  typedef struct packed {
    logic                      arvalid;
    logic [`MFT_ADDR_W-1:0]    araddr;
    logic                      rready;
  } mft_rreq_s;
  // slave answers
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mft_rsp_s;
  // whole timer state
  typedef struct packed {
    mft_bus_e    bus;
    mft_rsp_s    rsp;
    logic        aw_held;
    logic        w_held;
    logic [`MFT_ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0]  func_clk;
    logic [2:0]  cap_edge;
    logic [1:0]  pin_func;
    logic [3:0]  load_low;
    logic [3:0]  load_high;
    logic [7:0]  counter;
    logic [7:0]  read_pair;
    logic [11:0] prescale;
    logic [2:0]  pin_sync;
    logic        pin_last;
    logic        irq_flag;
    logic        cap_status;
    logic        cap_error;
    logic        stop;
    logic        irq_out;
  } mft_state_s;
endpackage : mft_pkg
`default_nettype wire

// ==== rtl/mft_timer.sv ====
// mft_timer.sv: multifunction 8-bit timer with axi4-lite register slave.
// assumes one 40 MHz clock, a synchronous active-low reset, and a pin that
// may change at any time relative to clk.
//
// Operation
// - function bit picks free-running or reload
// - clock field picks prescaler tap or pin
// - capture/edge register, 3 bits, cleared
// - capture bit selects input capture mode
// - edge field: none, fall, rise, both
// - 8-bit up counter, cleared at reset/stop
// - overflow sets interrupt request flag
// - free-running overflow wraps to zero
// - reload overflow loads write pair value
// - high nibble write loads counter immediately
// - low write nibble cleared at reset/stop
// - high read latches low nibble
// - capture mode read pair holds capture
// - read and write pairs share addresses
// - route bit switches pin to event input
// - clock field 111 counts chosen edges
// - capture edge copies, flags, clears counter
// - edge or overflow with status sets error
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
`include "mft_defs.svh"

module mft_timer
(
  // clock, reset, enable
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            clk_en,
  // axi4-lite requests
  input  wire mft_pkg::mft_wreq_s wreq,
  input  wire mft_pkg::mft_rreq_s rreq,
  // axi4-lite answers
  output var  mft_pkg::mft_rsp_s  rsp,
  // shared event pin
  input  wire logic            event_pin,
  // timer interrupt request level
  output logic                 timer_irq
);
  import mft_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  mft_state_s state_r;   // every flip-flop
  mft_state_s state_nxt; // next value

  // decoded controls
  logic       stop_entry;   // stop requested this cycle
  logic [2:0] clk_sel;      // tick source
  logic       capture_on;   // capture mode
  logic       tick;         // one-cycle count enable
  logic       edge_hit;     // selected edge seen
  logic       pin_prev;     // synchronised pin level
  logic       pin_now;      // agreed new level
  logic       rise;         // rising edge pulse
  logic       fall;         // falling edge pulse
  logic [11:0] tap_mask;    // prescaler terminal count
  logic       overflow;     // counter wraps this cycle
  logic [7:0] reload_val;   // write pair value
  logic       wr_fire;      // both write channels held
  logic [11:0] widx;        // write word index
  logic [11:0] ridx;        // read word index
  logic [31:0] rd_word;     // read data
  logic       rd_ok;        // read address mapped
  logic       wr_ok;        // write address mapped

  assign rsp       = state_r.rsp;
  assign timer_irq = state_r.irq_out;

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb
  begin
    state_nxt  = state_r;
    clk_sel    = state_r.func_clk[2:0];
    capture_on = state_r.cap_edge[`MFT_CAPTURE_BIT];
    stop_entry = 1'b0;
    reload_val = {state_r.load_high, state_r.load_low};
    widx       = state_r.waddr[13:2];
    ridx       = rreq.araddr[13:2];
    rd_word    = 32'h0000_0000;
    rd_ok      = 1'b1;
    wr_ok      = 1'b1;

    unique case (clk_sel)
      3'h0:    tap_mask = `MFT_DIV_2048;
      3'h1:    tap_mask = `MFT_DIV_512;
      3'h2:    tap_mask = `MFT_DIV_128;
      3'h3:    tap_mask = `MFT_DIV_32;
      3'h4:    tap_mask = `MFT_DIV_8;
      3'h5:    tap_mask = `MFT_DIV_4;
      3'h6:    tap_mask = `MFT_DIV_2;
      default: tap_mask = 12'h000;
    endcase

    // three-stage sync; a change counts once stages two and three agree
    state_nxt.pin_sync = {state_r.pin_sync[1:0], event_pin};
    pin_prev = state_r.pin_last;
    pin_now  = state_r.pin_sync[2];
    if (state_r.pin_sync[2] == state_r.pin_sync[1])
    begin
      state_nxt.pin_last = state_r.pin_sync[2];
    end
    else
    begin
      pin_now = pin_prev;
    end
    rise = pin_now & ~pin_prev;
    fall = ~pin_now & pin_prev;

    // pin only reaches the timer when routed; is software's part
    unique case (state_r.cap_edge[1:0])
      2'h1:    edge_hit = fall;
      2'h2:    edge_hit = rise;
      2'h3:    edge_hit = fall | rise;
      default: edge_hit = 1'b0;
    endcase
    edge_hit = edge_hit & state_r.pin_func[`MFT_ROUTE_BIT];

    // prescaler free-runs; tick is a single-cycle pulse at its tap
    state_nxt.prescale = state_r.prescale + 12'h001;
    // external clock comes from the edge detector in count modes
    if (clk_sel == `MFT_CLK_EXTERNAL)
    begin
      tick = edge_hit & ~capture_on;
    end
    else
    begin
      tick = ((state_r.prescale & tap_mask) == tap_mask);
    end

    overflow = tick & (state_r.counter == 8'hFF);

    if (tick)
    begin
      state_nxt.counter = state_r.counter + 8'h01;
    end
    if (overflow)
    begin
      state_nxt.irq_flag = 1'b1;
      // reload mode, not used while capturing
      if (state_r.func_clk[`MFT_RELOAD_BIT] && !capture_on)
      begin
        state_nxt.counter = reload_val;
      end
      else
      begin
        state_nxt.counter = 8'h00;
      end
      if (capture_on && state_r.cap_status)
      begin
        state_nxt.cap_error = 1'b1;
      end
    end

    if (capture_on && edge_hit)
    begin
      state_nxt.read_pair  = state_r.counter;
      state_nxt.counter    = 8'h00;
      state_nxt.irq_flag   = 1'b1;
      state_nxt.cap_status = 1'b1;
      if (state_r.cap_status)
      begin
        state_nxt.cap_error = 1'b1;
      end
    end

    // ************************************************************
    // axi4-lite write and read paths
    // ************************************************************
    state_nxt.rsp.awready = 1'b0;
    state_nxt.rsp.wready  = 1'b0;
    state_nxt.rsp.arready = 1'b0;
    // hold each channel independently
    if (wreq.awvalid && !state_r.aw_held && state_r.bus == MFT_BUS_IDLE && !state_r.rsp.awready)
    begin
      state_nxt.rsp.awready = 1'b1;
      state_nxt.aw_held     = 1'b1;
      state_nxt.waddr       = wreq.awaddr;
    end
    if (wreq.wvalid && !state_r.w_held && state_r.bus == MFT_BUS_IDLE && !state_r.rsp.wready)
    begin
      state_nxt.rsp.wready = 1'b1;
      state_nxt.w_held     = 1'b1;
      state_nxt.wdata      = wreq.wdata;
      if (wreq.wstrb[0] == 1'b0)
      begin
        state_nxt.wdata[7:0] = 8'h00;
      end
    end
    wr_fire = state_r.aw_held & state_r.w_held & (state_r.bus == MFT_BUS_IDLE);

    unique case (state_r.bus)
      MFT_BUS_IDLE:
      begin
        if (wr_fire)
        begin
          state_nxt.aw_held = 1'b0;
          state_nxt.w_held  = 1'b0;
          state_nxt.bus     = MFT_BUS_WRSP;
          state_nxt.rsp.bvalid = 1'b1;
          // writes at shared addresses go to the write nibbles
          if (widx == `MFT_IDX_LOAD_LOW)
          begin
            state_nxt.load_low = state_r.wdata[3:0];
          end
          else if (widx == `MFT_IDX_LOAD_HIGH)
          begin
            // high nibble loads counter at once
            state_nxt.load_high = state_r.wdata[3:0];
            state_nxt.counter   = {state_r.wdata[3:0], state_r.load_low};
          end
          else if (widx == `MFT_IDX_FUNC_CLK)
          begin
            state_nxt.func_clk = state_r.wdata[3:0];
          end
          else if (widx == `MFT_IDX_CAP_EDGE)
          begin
            state_nxt.cap_edge = state_r.wdata[2:0];
            if (state_r.wdata[`MFT_CAPTURE_BIT] && !capture_on)
            begin
              state_nxt.counter = 8'h00;
            end
          end
          else if (widx == `MFT_IDX_PIN_FUNC)
          begin
            state_nxt.pin_func = state_r.wdata[1:0];
          end
          else if (widx == `MFT_IDX_STATUS)
          begin
            // writing 0 clears; a same-cycle set still wins
            if (!state_r.wdata[`MFT_ST_IRQ_BIT] && !state_nxt.irq_flag)
            begin
              state_nxt.irq_flag = 1'b0;
            end
            else if (!state_r.wdata[`MFT_ST_IRQ_BIT] && !(overflow || (capture_on && edge_hit)))
            begin
              state_nxt.irq_flag = 1'b0;
            end
            if (!state_r.wdata[`MFT_ST_CSF_BIT] && !(capture_on && edge_hit))
            begin
              state_nxt.cap_status = 1'b0;
            end
            // an error raised by an edge or overflow this cycle outranks the clear
            if (!state_r.wdata[`MFT_ST_CEF_BIT] && !(capture_on && state_r.cap_status && (edge_hit || overflow)))
            begin
              state_nxt.cap_error = 1'b0;
            end
          end
          else if (widx == `MFT_IDX_CONTROL)
          begin
            stop_entry = state_r.wdata[`MFT_CTL_STOP_BIT];
          end
          else
          begin
            wr_ok = 1'b0;
          end
          state_nxt.rsp.bresp = wr_ok ? MFT_RESP_OKAY : MFT_RESP_SLVERR;
        end
        else if (rreq.arvalid)
        begin
          state_nxt.rsp.arready = 1'b1;
          state_nxt.bus         = MFT_BUS_RRSP;
          state_nxt.rsp.rvalid  = 1'b1;
          if (ridx == `MFT_IDX_LOAD_HIGH)
          begin
            if (capture_on)
            begin
              rd_word[3:0] = state_r.read_pair[7:4];
            end
            else
            begin
              rd_word[3:0] = state_r.counter[7:4];
              state_nxt.read_pair[3:0] = state_r.counter[3:0];
            end
          end
          else if (ridx == `MFT_IDX_LOAD_LOW)
          begin
            rd_word[3:0] = state_r.read_pair[3:0];
          end
          else if (ridx == `MFT_IDX_STATUS)
          begin
            rd_word[2:0] = {state_r.cap_error, state_r.cap_status, state_r.irq_flag};
          end
          else if (ridx == `MFT_IDX_CONTROL)
          begin
            rd_word[0] = state_r.stop;
          end
          else
          begin
            rd_ok = 1'b0;
          end
          state_nxt.rsp.rdata = rd_word;
          state_nxt.rsp.rresp = rd_ok ? MFT_RESP_OKAY : MFT_RESP_SLVERR;
        end
      end
      MFT_BUS_WRSP:
      begin
        if (wreq.bready)
        begin
          state_nxt.rsp.bvalid = 1'b0;
          state_nxt.bus        = MFT_BUS_IDLE;
        end
      end
      MFT_BUS_RRSP:
      begin
        if (rreq.rready)
        begin
          state_nxt.rsp.rvalid = 1'b0;
          state_nxt.bus        = MFT_BUS_IDLE;
        end
      end
    endcase

    // stop mode holds counter, prescaler and modes at reset values; irq flag, high nibble and route bit keep theirs
    state_nxt.stop = stop_entry | (state_r.stop & ~(widx == `MFT_IDX_CONTROL && wr_fire));
    if (stop_entry || state_r.stop)
    begin
      // stop clears counter, low nibble, modes
      state_nxt.counter    = 8'h00;
      state_nxt.load_low   = `MFT_LOAD_LOW_RST;
      state_nxt.func_clk   = `MFT_FUNC_CLK_RST;
      state_nxt.cap_edge   = `MFT_CAP_EDGE_RST;
      state_nxt.cap_status = 1'b0;
      state_nxt.cap_error  = 1'b0;
      state_nxt.prescale   = 12'h000;
    end
    state_nxt.irq_out = state_nxt.irq_flag;
  end

  // ************************************************************
  // registers
  // ************************************************************
  // one flop set; clock enable freezes it all
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r          <= '0;
      state_r.bus      <= MFT_BUS_IDLE;
      state_r.func_clk <= `MFT_FUNC_CLK_RST;
      state_r.cap_edge <= `MFT_CAP_EDGE_RST;
      state_r.load_low <= `MFT_LOAD_LOW_RST;
      state_r.pin_func <= `MFT_PIN_FUNC_RST;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
    end
  end
endmodule // mft_timer
`default_nettype wire
